/* File: cmp_defines.svh */
// Offsets, field positions, reset values and select codes of the comparator mode/input registers.
// Assumes an 8-bit special-function-register port on a single clock.
// Summary of operation
// [RQ1] Mode register bit 7 always reads one; software must write one.
// [RQ2] Mode register bits 6 and 3:2 read zero and ignore writes.
// [RQ3] Mode bit 5 enables the second comparator's rising-edge interrupt.
// [RQ4] Mode bit 4 enables the second comparator's falling-edge interrupt.
// [RQ5] Mode bits 1:0 pick speed/power; 00 fastest, 11 lowest power.
// [RQ6] Input-select bits 7:4 pick the first comparator's negative input.
// [RQ7] Input-select bits 3:0 pick the first comparator's positive input.
// [RQ8] Compare code on either mux enables the capacitive-sense reference level.
// [RQ9] First comparator output can be routed to the timer capture input.
// [RQ10] Supply halving divider enabled only while a mux selects half-supply.
// [RQ11] Software configures comparator input pins as analog and crossbar-skipped.
// [RQ12] Edge flags are sticky; set on edges, cleared only by writing zero.
// [RQ13] Interrupt request while a flag and its enable are both set.
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH
`define CMP_MODE_ADDR 8'h9c
`define CMP_MUX_ADDR 8'h9f
`define CMP_FLAG_ADDR 8'h9a
`define CMP_MODE_RESET 8'h82
`define CMP_MUX_RESET 8'hff
`define CMP_MODE_RSVD_BIT 7
`define CMP_MODE_RIE_BIT 5
`define CMP_MODE_FIE_BIT 4
`define CMP_FLAG_RIF_BIT 5
`define CMP_FLAG_FIF_BIT 4
`define CMP_SEL_COMPARE 4'hc
`define CMP_SEL_HALF 4'hd
`define CMP_NEG_DIGITAL 4'he
`define CMP_NEG_GROUND 4'hf
`endif

/* File: cmp_pkg.sv */
// Types shared by the comparator control block.
// Assumes nothing of its surroundings.
package cmp_pkg;
	typedef enum logic [3:0] {
		SEL_PIN = 4'h1,
		SEL_COMPARE = 4'h2,
		SEL_SUPPLY = 4'h4,
		SEL_RESERVED = 4'h8
	} sel_class_type;
	typedef logic [1:0] speed_mode_type;
endpackage : cmp_pkg

/* File: cmp_sel_if.sv */
// Decoded analog-multiplexer selections between the register bank and decoder.
// Assumes one clock domain.
`timescale 1ns/100ps
interface cmp_sel_if;
	logic [3:0] negative_input_code;
	logic [3:0] positive_input_code;
	cmp_pkg::sel_class_type neg_class;
	cmp_pkg::sel_class_type pos_class;
	logic compare_ref_en;
	logic half_div_en;
	modport bank (output negative_input_code, output positive_input_code,
		input neg_class, input pos_class, input compare_ref_en, input half_div_en);
	modport decoder (input negative_input_code, input positive_input_code,
		output neg_class, output pos_class, output compare_ref_en, output half_div_en);
endinterface : cmp_sel_if

/* File: cmp_mux_decode.sv */
// Registered decode of the comparator input selection codes.
// Assumes codes come from the register bank on the same clock.
`timescale 1ns/100ps
`include "cmp_defines.svh"
module cmp_mux_decode
(
	input wire logic sys_clk,
	input wire logic rst_n,
	cmp_sel_if.decoder sel
);
	cmp_pkg::sel_class_type neg_ff, nxt_neg, pos_ff, nxt_pos;
	logic cref_ff, nxt_cref, half_ff, nxt_half;

	always_comb
	begin
		case (sel.negative_input_code) // RQ6
			4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9: nxt_neg = cmp_pkg::SEL_PIN;
			`CMP_SEL_COMPARE: nxt_neg = cmp_pkg::SEL_COMPARE;
			`CMP_SEL_HALF, `CMP_NEG_DIGITAL, `CMP_NEG_GROUND: nxt_neg = cmp_pkg::SEL_SUPPLY;
			default: nxt_neg = cmp_pkg::SEL_RESERVED;
		endcase
		case (sel.positive_input_code) // RQ7
			4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9: nxt_pos = cmp_pkg::SEL_PIN;
			`CMP_SEL_COMPARE: nxt_pos = cmp_pkg::SEL_COMPARE;
			4'hd, 4'he, 4'hf: nxt_pos = cmp_pkg::SEL_SUPPLY;
			default: nxt_pos = cmp_pkg::SEL_RESERVED;
		endcase
		nxt_cref = (sel.negative_input_code == `CMP_SEL_COMPARE) ||
			(sel.positive_input_code == `CMP_SEL_COMPARE); // RQ8
		nxt_half = (sel.negative_input_code == `CMP_SEL_HALF) ||
			(sel.positive_input_code == `CMP_SEL_HALF); // RQ10
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			neg_ff <= cmp_pkg::SEL_SUPPLY;
			pos_ff <= cmp_pkg::SEL_SUPPLY;
			cref_ff <= 1'b0;
			half_ff <= 1'b0;
		end
		else
		begin
			neg_ff <= nxt_neg;
			pos_ff <= nxt_pos;
			cref_ff <= nxt_cref;
			half_ff <= nxt_half;
		end
	end

	assign sel.neg_class = neg_ff;
	assign sel.pos_class = pos_ff;
	assign sel.compare_ref_en = cref_ff;
	assign sel.half_div_en = half_ff;

	chk_half_follows_code: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		(sel.positive_input_code == `CMP_SEL_HALF) |=> sel.half_div_en)
		else $error("divider not enabled for half-supply code");
	chk_cref_needs_code: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
		sel.compare_ref_en |-> ($past(sel.negative_input_code) == `CMP_SEL_COMPARE) ||
		($past(sel.positive_input_code) == `CMP_SEL_COMPARE))
		else $error("compare reference on without compare code");
endmodule : cmp_mux_decode

/* File: cmp_ctrl.sv */
// Comparator mode and input-select register bank with edge flags and interrupt request.
// Assumes a synchronous SFR port: one-cycle write strobe, combinational address for reads.
`timescale 1ns/100ps
`include "cmp_defines.svh"
module cmp_ctrl
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic cmp1_out,
	input wire logic cmp0_out,
	input wire logic timer_capture_route,
	output logic [7:0] sfr_rdata,
	output logic irq,
	output logic [1:0] speed_power_mode,
	output logic [3:0] negative_input_code,
	output logic [3:0] positive_input_code,
	output logic compare_ref_en,
	output logic half_div_en,
	output logic timer_capture
);
	logic rie_ff, nxt_rie, fie_ff, nxt_fie;
	cmp_pkg::speed_mode_type mode_ff, nxt_mode;
	logic [7:0] mux_ff, nxt_mux;
	logic rif_ff, nxt_rif, fif_ff, nxt_fif;
	logic cmp_d_ff, nxt_cmp_d;
	logic armed_ff, nxt_armed;
	logic [7:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic cref_ff, half_ff, cap_ff, nxt_cap;
	logic wr_mode, wr_mux, wr_flag, rise, fall;
	cmp_sel_if sel ();

	assign wr_mode = sfr_wr && (sfr_addr == `CMP_MODE_ADDR);
	assign wr_mux = sfr_wr && (sfr_addr == `CMP_MUX_ADDR);
	assign wr_flag = sfr_wr && (sfr_addr == `CMP_FLAG_ADDR);
	// Edge detector ignores the first cycle after reset, so a level is no edge
	assign rise = armed_ff && cmp1_out && !cmp_d_ff;
	assign fall = armed_ff && !cmp1_out && cmp_d_ff;

	always_comb
	begin
		nxt_rie = rie_ff;
		nxt_fie = fie_ff;
		nxt_mode = mode_ff;
		nxt_mux = mux_ff;
		if (wr_mode)
		begin
			nxt_rie = sfr_wdata[`CMP_MODE_RIE_BIT]; // RQ3
			nxt_fie = sfr_wdata[`CMP_MODE_FIE_BIT]; // RQ4
			nxt_mode = sfr_wdata[1:0]; // RQ5
		end
		if (wr_mux)
		begin
			nxt_mux = sfr_wdata; // RQ6 RQ7
		end
	end

	always_comb
	begin
		nxt_cmp_d = cmp1_out;
		nxt_armed = 1'b1;
		nxt_rif = rif_ff;
		nxt_fif = fif_ff;
		if (wr_flag && !sfr_wdata[`CMP_FLAG_RIF_BIT])
		begin
			nxt_rif = 1'b0;
		end
		if (wr_flag && !sfr_wdata[`CMP_FLAG_FIF_BIT])
		begin
			nxt_fif = 1'b0;
		end
		if (rise)
		begin
			nxt_rif = 1'b1; // RQ12
		end
		if (fall)
		begin
			nxt_fif = 1'b1; // RQ12
		end
		nxt_irq = (nxt_rif && nxt_rie) || (nxt_fif && nxt_fie); // RQ13
		nxt_cap = timer_capture_route && cmp0_out; // RQ9
	end

	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (sfr_rd)
		begin
			case (sfr_addr)
				`CMP_MODE_ADDR: nxt_rdata = {1'b1, 1'b0, rie_ff, fie_ff, 2'b00, mode_ff}; // RQ1 RQ2
				`CMP_MUX_ADDR: nxt_rdata = mux_ff;
				`CMP_FLAG_ADDR: nxt_rdata = {2'b00, rif_ff, fif_ff, 4'h0};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rie_ff <= 1'b0;
			fie_ff <= 1'b0;
			mode_ff <= 2'h2;
			mux_ff <= `CMP_MUX_RESET;
			rif_ff <= 1'b0;
			fif_ff <= 1'b0;
			cmp_d_ff <= 1'b0;
			armed_ff <= 1'b0;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
			cap_ff <= 1'b0;
		end
		else
		begin
			rie_ff <= nxt_rie;
			fie_ff <= nxt_fie;
			mode_ff <= nxt_mode;
			mux_ff <= nxt_mux;
			rif_ff <= nxt_rif;
			fif_ff <= nxt_fif;
			cmp_d_ff <= nxt_cmp_d;
			armed_ff <= nxt_armed;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
			cap_ff <= nxt_cap;
		end
	end

	assign sel.negative_input_code = mux_ff[7:4];
	assign sel.positive_input_code = mux_ff[3:0];

	cmp_mux_decode u_decode
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sel(sel)
	);

	// Re-time decoder outputs so top outputs come from local flops
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cref_ff <= 1'b0;
			half_ff <= 1'b0;
		end
		else
		begin
			cref_ff <= sel.compare_ref_en;
			half_ff <= sel.half_div_en;
		end
	end

	assign sfr_rdata = rdata_ff;
	assign irq = irq_ff;
	assign speed_power_mode = mode_ff;
	assign negative_input_code = mux_ff[7:4];
	assign positive_input_code = mux_ff[3:0];
	assign compare_ref_en = cref_ff;
	assign half_div_en = half_ff;
	assign timer_capture = cap_ff;

	chk_mode_readback: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
		(sfr_rd && sfr_addr == `CMP_MODE_ADDR) |=> sfr_rdata[7])
		else $error("reserved mode bit read as zero");
	chk_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
		(sfr_rd && sfr_addr == `CMP_MODE_ADDR) |=> (sfr_rdata[6] == 1'b0) && (sfr_rdata[3:2] == 2'b00))
		else $error("unused mode bits not zero");
	chk_rie_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
		wr_mode |=> rie_ff == $past(sfr_wdata[5]))
		else $error("rising enable not written");
	chk_fie_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
		wr_mode |=> fie_ff == $past(sfr_wdata[4]))
		else $error("falling enable not written");
	chk_mode_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5
		wr_mode |=> speed_power_mode == $past(sfr_wdata[1:0]))
		else $error("speed mode not written");
	chk_mux_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
		wr_mux |=> {negative_input_code, positive_input_code} == $past(sfr_wdata))
		else $error("input select not written");
	chk_rise_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		rise |=> rif_ff ##1 (rif_ff || $past(wr_flag)))
		else $error("rising flag lost");
	chk_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		(fif_ff && !wr_flag) |=> fif_ff)
		else $error("falling flag cleared without write");
	chk_irq_cause: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
		irq |-> (rif_ff && rie_ff) || (fif_ff && fie_ff))
		else $error("interrupt without enabled flag");
	chk_capture_route: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
		(timer_capture_route && cmp0_out) |=> timer_capture)
		else $error("capture not routed");
	chk_half_out: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		half_div_en |-> $past(negative_input_code, 2) == `CMP_SEL_HALF ||
		$past(positive_input_code, 2) == `CMP_SEL_HALF)
		else $error("divider on without half-supply code");
	chk_neg_class: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
		(negative_input_code == `CMP_SEL_COMPARE) |=> (sel.neg_class == cmp_pkg::SEL_COMPARE))
		else $error("negative compare code not decoded");
	chk_pos_class: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
		(positive_input_code == `CMP_SEL_COMPARE) |=> (sel.pos_class == cmp_pkg::SEL_COMPARE))
		else $error("positive compare code not decoded");
endmodule : cmp_ctrl

/* File: test_comparator_mode_and_input_select.sv */
// Self-checking bench for the comparator mode and input-select register bank.
// Assumes cmp_ctrl, its package, interface and defines are compiled before it.
`timescale 1ns/100ps
`include "cmp_defines.svh"
`define bench_check(act, exp) \
	begin \
		checks++; \
		if ((act) !== (exp)) \
		begin \
			n_fail++; \
			$display("BAD t=%0t got=%h exp=%h", $time, act, exp); \
		end \
	end
module test_comparator_mode_and_input_select;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] w;
		logic [7:0] r;
		logic [1:0] m;
		logic [3:0] n;
		logic [3:0] p;
		logic c;
		logic h;
	} row_type;
	// Address, write data, read back, then mode, codes and enables expected
	// Pin codes assume pins already analog and crossbar-skipped
	row_type rows [10] = '{
		'{8'h9c, 8'hff, 8'hb3, 2'h3, 4'hf, 4'hf, 1'b0, 1'b0},
		'{8'h9c, 8'h80, 8'h80, 2'h0, 4'hf, 4'hf, 1'b0, 1'b0},
		'{8'h9c, 8'h91, 8'h91, 2'h1, 4'hf, 4'hf, 1'b0, 1'b0},
		'{8'h9c, 8'hae, 8'ha2, 2'h2, 4'hf, 4'hf, 1'b0, 1'b0},
		'{8'h9f, 8'hc5, 8'hc5, 2'h2, 4'hc, 4'h5, 1'b1, 1'b0},
		'{8'h9f, 8'h3d, 8'h3d, 2'h2, 4'h3, 4'hd, 1'b0, 1'b1},
		'{8'h9f, 8'hdc, 8'hdc, 2'h2, 4'hd, 4'hc, 1'b1, 1'b1},
		'{8'h9f, 8'h00, 8'h00, 2'h2, 4'h0, 4'h0, 1'b0, 1'b0},
		'{8'h9f, 8'hef, 8'hef, 2'h2, 4'he, 4'hf, 1'b0, 1'b0},
		'{8'h50, 8'h12, 8'h00, 2'h2, 4'he, 4'hf, 1'b0, 1'b0}
	};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic cmp1_out = 1'b0;
	logic cmp0_out = 1'b0;
	logic timer_capture_route = 1'b0;
	logic [7:0] sfr_rdata;
	logic irq;
	logic [1:0] speed_power_mode;
	logic [3:0] negative_input_code;
	logic [3:0] positive_input_code;
	logic compare_ref_en;
	logic half_div_en;
	logic timer_capture;
	logic [7:0] v;
	int n_fail = 0;
	int checks = 0;
	int cycles = 0;
	cmp_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .cmp1_out(cmp1_out), .cmp0_out(cmp0_out),
		.timer_capture_route(timer_capture_route), .sfr_rdata(sfr_rdata), .irq(irq),
		.speed_power_mode(speed_power_mode), .negative_input_code(negative_input_code),
		.positive_input_code(positive_input_code), .compare_ref_en(compare_ref_en),
		.half_div_en(half_div_en), .timer_capture(timer_capture));
	always #2 sys_clk = ~sys_clk;
	task test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			test_done();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// Entered just after a rising edge; returns at the edge that takes the write
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
	endtask : wr
	// Read data is registered at the taking edge and held, so sample one edge later
	task rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		@(posedge sys_clk);
		d = sfr_rdata;
	endtask : rd
	initial
	begin
		cyc(5);
		rst_n <= 1'b1;
		rd(`CMP_MODE_ADDR, v);
		`bench_check(v, 8'h82)
		rd(`CMP_MUX_ADDR, v);
		`bench_check(v, 8'hff)
		`bench_check(irq, 1'b0)
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, v);
			`bench_check(v, rows[i].r)
			cyc(1);
			`bench_check(speed_power_mode, rows[i].m)
			`bench_check(negative_input_code, rows[i].n)
			`bench_check(positive_input_code, rows[i].p)
			`bench_check(compare_ref_en, rows[i].c)
			`bench_check(half_div_en, rows[i].h)
		end
		// Edge flags against the interrupt enables
		wr(`CMP_MODE_ADDR, 8'hb0);
		cmp1_out <= 1'b1;
		cyc(3);
		`bench_check(irq, 1'b1)
		cmp1_out <= 1'b0;
		cyc(1);
		rd(`CMP_FLAG_ADDR, v);
		`bench_check(v, 8'h30)
		wr(`CMP_FLAG_ADDR, 8'h10);
		rd(`CMP_FLAG_ADDR, v);
		`bench_check(v, 8'h10)
		`bench_check(irq, 1'b1)
		wr(`CMP_MODE_ADDR, 8'ha0);
		cyc(2);
		`bench_check(irq, 1'b0)
		wr(`CMP_FLAG_ADDR, 8'h00);
		cmp1_out <= 1'b1;
		cyc(3);
		`bench_check(irq, 1'b1)
		wr(`CMP_FLAG_ADDR, 8'h00);
		cyc(2);
		`bench_check(irq, 1'b0)
		rd(`CMP_FLAG_ADDR, v);
		`bench_check(v, 8'h00)
		// Capture routing over all four input combinations
		for (int k = 0; k < 4; k++)
		begin
			cmp0_out <= k[0];
			timer_capture_route <= k[1];
			cyc(3);
			`bench_check(timer_capture, k[0] & k[1])
		end
		// Second reset in mid-run
		rst_n <= 1'b0;
		cyc(2);
		`bench_check(speed_power_mode, 2'h2)
		`bench_check(negative_input_code, 4'hf)
		`bench_check(irq, 1'b0)
		`bench_check(timer_capture, 1'b0)
		// Release with the comparator high: no false rising edge
		rst_n <= 1'b1;
		rd(`CMP_MODE_ADDR, v);
		`bench_check(v, 8'h82)
		rd(`CMP_FLAG_ADDR, v);
		`bench_check(v, 8'h00)
		`bench_check(irq, 1'b0)
		test_done();
	end
endmodule : test_comparator_mode_and_input_select
